/* rtl/eeprom_pkg.sv */
package eeprom_pkg;
   localparam int unsigned ADDR_W = 13;
   localparam int unsigned MEM_BYTES = 8192;
   localparam int unsigned PAGE_W = 5;
   localparam int unsigned PAGE_BYTES = 32;
   localparam int unsigned BYTE_BITS = 8;
   localparam logic [3:0] BIT_COUNT_FULL = 4'h8;

   // Slave address byte layout
   localparam int unsigned SA_SELECT_ONE_BIT = 7;
   localparam int unsigned SA_SELECT_TWO_BIT = 6;
   localparam int unsigned SA_UPPER_MSB = 5;
   localparam int unsigned SA_UPPER_LSB = 1;
   localparam int unsigned SA_READ_BIT = 0;

   // Protect register, at the top array address
   localparam logic [12:0] REG_ADDR = 13'h1fff;
   localparam int unsigned ARM_BIT = 7;
   localparam int unsigned ZERO_HI_BIT = 6;
   localparam int unsigned ZERO_LO_BIT = 5;
   localparam int unsigned BLOCK_HIGH_BIT = 4;
   localparam int unsigned BLOCK_LOW_BIT = 3;
   localparam int unsigned REG_LATCH_BIT = 2;
   localparam int unsigned SW_LATCH_BIT = 1;
   localparam logic [1:0] BLOCK_PROTECT_RESET = 2'h0;
   localparam logic ARM_RESET = 1'b0;

   // Block protect encoding and region bases
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [12:0] QUARTER_BASE = 13'h1800;
   localparam logic [12:0] HALF_BASE = 13'h1000;

   // Internal programming time
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned WRITE_TIME_NS = 5000000;
   localparam int unsigned WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_tx_ack} bit_state_t;
   typedef enum logic [1:0] {ph_slave, ph_addr, ph_data, ph_read} phase_t;
   typedef enum logic [1:0] {cm_idle, cm_drain, cm_hold} commit_t;
endpackage : eeprom_pkg

/* rtl/line_events_if.sv */
`timescale 1ns/100ps
interface line_events_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   modport source (output scl_rise, output scl_fall, output start, output stop, output sda);
   modport sink (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : line_events_if

/* rtl/line_sampler.sv */
`timescale 1ns/100ps
module line_sampler (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   line_events_if.source ev
);
   // Stage 0 is the synchroniser front, stage 2 the edge history
   logic [2:0] scl_q;
   logic [2:0] sda_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end
      else
      begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda};
      end
   end

   assign ev.scl_rise = scl_q[1] & ~scl_q[2];
   assign ev.scl_fall = ~scl_q[1] & scl_q[2];
   assign ev.start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign ev.stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   assign ev.sda = sda_q[1];
endmodule : line_sampler

/* rtl/stream_fifo.sv */
`timescale 1ns/100ps
module stream_fifo #(
   parameter int unsigned WIDTH = 13,
   parameter int unsigned DEPTH = 32
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_flush,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int unsigned PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PTR_W:0] wptr;
   logic [PTR_W:0] rptr;
   wire do_write = i_wr_valid & o_wr_ready;
   wire do_read = o_rd_valid & i_rd_ready;

   assign o_rd_valid = wptr != rptr;
   assign o_wr_ready = (wptr[PTR_W-1:0] != rptr[PTR_W-1:0]) || (wptr[PTR_W] == rptr[PTR_W]);
   assign o_rd_data = store[rptr[PTR_W-1:0]];

   always_ff @(posedge i_clk)
   begin
      if (do_write)
         store[wptr[PTR_W-1:0]] <= i_wr_data;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || i_flush)
      begin
         wptr <= '0;
         rptr <= '0;
      end
      else
      begin
         wptr <= wptr + (PTR_W+1)'(do_write);
         rptr <= rptr + (PTR_W+1)'(do_read);
      end
   end
endmodule : stream_fifo

/* rtl/two_wire_eeprom_slave_port.sv */
`timescale 1ns/100ps
module two_wire_eeprom_slave_port #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
   parameter int unsigned PAGE_BYTES = eeprom_pkg::PAGE_BYTES,
   parameter logic [1:0] BLOCK_PROTECT_RESET = eeprom_pkg::BLOCK_PROTECT_RESET,
   parameter logic ARM_RESET = eeprom_pkg::ARM_RESET
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_select_pin_one,
   input wire logic i_select_pin_two_inverted_n,
   input wire logic i_write_protect,
   output logic o_busy
);
   localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam int unsigned ENTRY_W = eeprom_pkg::PAGE_W + eeprom_pkg::BYTE_BITS;
   localparam int unsigned AW = eeprom_pkg::ADDR_W;
   localparam int unsigned PW = eeprom_pkg::PAGE_W;

   line_events_if ev ();

   line_sampler u_sampler (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .ev(ev.source)
   );

   // Block region decode, used only by the write path; the commit path does not check it
   function automatic logic block_hit(input logic [12:0] a, input logic [1:0] bp);
      logic hit;
      hit = 1'b1;
      if (bp == eeprom_pkg::BP_NONE)
         hit = 1'b0;
      else if (bp == eeprom_pkg::BP_QUARTER)
         hit = a >= eeprom_pkg::QUARTER_BASE;
      else if (bp == eeprom_pkg::BP_HALF)
         hit = a >= eeprom_pkg::HALF_BASE;
      return hit;
   endfunction : block_hit

   eeprom_pkg::bit_state_t state;
   eeprom_pkg::phase_t phase;
   eeprom_pkg::commit_t cstate;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [AW-1:0] addr;
   logic first_data;
   logic first_read;
   logic pushed;
   logic master_ack;
   logic reg_pending;
   logic [7:0] reg_data;
   logic sw_latch;
   logic reg_latch;
   logic [1:0] block_protect;
   logic arm;
   logic [1:0] sel_one_q;
   logic [1:0] sel_two_n_q;
   logic [1:0] wp_q;
   logic [CNT_W-1:0] cnt;
   logic [7:0] mem [0:eeprom_pkg::MEM_BYTES-1];
   logic push_valid;
   logic [ENTRY_W-1:0] push_data;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic [ENTRY_W-1:0] fifo_rd_data;

   // Pins from outside the clock domain
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         sel_one_q <= 2'h0;
         sel_two_n_q <= 2'h3;
         wp_q <= 2'h3;
      end
      else
      begin
         sel_one_q <= {sel_one_q[0], i_select_pin_one};
         sel_two_n_q <= {sel_two_n_q[0], i_select_pin_two_inverted_n};
         wp_q <= {wp_q[0], i_write_protect};
      end
   end

   wire busy = cstate != eeprom_pkg::cm_idle;
   wire byte_done = ev.scl_fall && state == eeprom_pkg::st_rx && bit_cnt == eeprom_pkg::BIT_COUNT_FULL;
   // A stop always follows the SCL rise of a new byte's first bit, so one shifted bit still counts as a boundary
   wire boundary = state == eeprom_pkg::st_idle || (state == eeprom_pkg::st_rx && bit_cnt <= 4'h1);
   wire slave_match = shift[eeprom_pkg::SA_SELECT_ONE_BIT] == sel_one_q[1] &&
                      shift[eeprom_pkg::SA_SELECT_TWO_BIT] == ~sel_two_n_q[1];
   wire at_reg = addr == eeprom_pkg::REG_ADDR;
   wire reg_lock = wp_q[1] & arm;
   wire take_reg = at_reg && first_data;
   wire data_ok = take_reg || (sw_latch && fifo_wr_ready);
   wire data_push = !take_reg && sw_latch && fifo_wr_ready && !block_hit(addr, block_protect);
   wire clean_stop = ev.stop && boundary && phase == eeprom_pkg::ph_data;
   wire reg_nv_write = reg_pending && sw_latch && reg_latch && reg_data[eeprom_pkg::SW_LATCH_BIT] &&
                       !reg_data[eeprom_pkg::REG_LATCH_BIT] && !reg_data[eeprom_pkg::ZERO_HI_BIT] &&
                       !reg_data[eeprom_pkg::ZERO_LO_BIT] && !reg_lock;
   wire commit_go = clean_stop && (pushed || reg_nv_write);
   wire flush = (ev.start && !busy) || (ev.stop && !clean_stop);
   wire [7:0] reg_value = {arm, 2'h0, block_protect, reg_latch, sw_latch, 1'b0};
   wire [7:0] tx_byte = (first_read && at_reg) ? reg_value : mem[addr];
   wire ack_now = (phase == eeprom_pkg::ph_slave) ? slave_match :
                  (phase == eeprom_pkg::ph_addr) ? 1'b1 : data_ok;
   wire load_tx = ev.scl_fall && ((state == eeprom_pkg::st_ack && phase == eeprom_pkg::ph_read) ||
                  (state == eeprom_pkg::st_tx_ack && master_ack));
   wire [AW-1:0] commit_addr = {addr[AW-1:PW], fifo_rd_data[ENTRY_W-1:eeprom_pkg::BYTE_BITS]};

   assign o_sda = 1'b0;
   assign o_busy = busy;

   // Bit engine
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         state <= eeprom_pkg::st_idle;
         phase <= eeprom_pkg::ph_slave;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         o_sda_oe <= 1'b0;
         master_ack <= 1'b0;
      end
      else if (busy)
      begin
         state <= eeprom_pkg::st_idle;
         o_sda_oe <= 1'b0;
      end
      else if (ev.start)
      begin
         state <= eeprom_pkg::st_rx;
         phase <= eeprom_pkg::ph_slave;
         bit_cnt <= 4'h0;
         o_sda_oe <= 1'b0;
      end
      else if (ev.stop)
      begin
         state <= eeprom_pkg::st_idle;
         o_sda_oe <= 1'b0;
      end
      else
      begin
         unique case (state)
            eeprom_pkg::st_idle:
            begin
               o_sda_oe <= 1'b0;
            end
            eeprom_pkg::st_rx:
            begin
               if (ev.scl_rise && bit_cnt != eeprom_pkg::BIT_COUNT_FULL)
               begin
                  shift <= {shift[6:0], ev.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (byte_done)
               begin
                  if (ack_now)
                  begin
                     o_sda_oe <= 1'b1;
                     state <= eeprom_pkg::st_ack;
                     if (phase == eeprom_pkg::ph_slave)
                        phase <= shift[eeprom_pkg::SA_READ_BIT] ? eeprom_pkg::ph_read : eeprom_pkg::ph_addr;
                     else if (phase == eeprom_pkg::ph_addr)
                        phase <= eeprom_pkg::ph_data;
                  end
                  else
                     state <= eeprom_pkg::st_idle;
               end
            end
            eeprom_pkg::st_ack:
            begin
               if (load_tx)
               begin
                  shift <= tx_byte;
                  o_sda_oe <= ~tx_byte[7];
                  bit_cnt <= 4'h1;
                  state <= eeprom_pkg::st_tx;
               end
               else if (ev.scl_fall)
               begin
                  o_sda_oe <= 1'b0;
                  bit_cnt <= 4'h0;
                  state <= eeprom_pkg::st_rx;
               end
            end
            eeprom_pkg::st_tx:
            begin
               if (ev.scl_fall && bit_cnt == eeprom_pkg::BIT_COUNT_FULL)
               begin
                  o_sda_oe <= 1'b0;
                  state <= eeprom_pkg::st_tx_ack;
               end
               else if (ev.scl_fall)
               begin
                  o_sda_oe <= ~shift[6];
                  shift <= {shift[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            eeprom_pkg::st_tx_ack:
            begin
               if (ev.scl_rise)
                  master_ack <= ~ev.sda;
               else if (load_tx)
               begin
                  shift <= tx_byte;
                  o_sda_oe <= ~tx_byte[7];
                  bit_cnt <= 4'h1;
                  state <= eeprom_pkg::st_tx;
               end
               else if (ev.scl_fall)
                  state <= eeprom_pkg::st_idle;
            end
         endcase
      end
   end

   // Address counter and write staging
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         addr <= '0;
         first_data <= 1'b0;
         first_read <= 1'b0;
         pushed <= 1'b0;
         reg_pending <= 1'b0;
         reg_data <= 8'h00;
         push_valid <= 1'b0;
         push_data <= '0;
      end
      else
      begin
         push_valid <= 1'b0;
         if (flush || commit_go || (ev.stop && !busy))
         begin
            pushed <= 1'b0;
            reg_pending <= 1'b0;
         end
         if (byte_done && !busy && ack_now)
         begin
            unique case (phase)
               eeprom_pkg::ph_slave:
               begin
                  addr[AW-1:8] <= shift[eeprom_pkg::SA_UPPER_MSB:eeprom_pkg::SA_UPPER_LSB];
                  first_read <= 1'b1;
               end
               eeprom_pkg::ph_addr:
               begin
                  addr[7:0] <= shift;
                  first_data <= 1'b1;
               end
               eeprom_pkg::ph_data:
               begin
                  first_data <= 1'b0;
                  if (take_reg)
                  begin
                     reg_pending <= 1'b1;
                     reg_data <= shift;
                  end
                  else
                  begin
                     addr[PW-1:0] <= addr[PW-1:0] + 5'h01;
                     push_valid <= data_push;
                     push_data <= {addr[PW-1:0], shift};
                     pushed <= pushed | data_push;
                  end
               end
               eeprom_pkg::ph_read:
               begin
               end
            endcase
         end
         if (load_tx)
         begin
            addr <= addr + 13'h0001;
            first_read <= 1'b0;
         end
      end
   end

   // Protect register latches and bits
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         sw_latch <= 1'b0;
         reg_latch <= 1'b0;
         block_protect <= BLOCK_PROTECT_RESET;
         arm <= ARM_RESET;
      end
      else if (clean_stop && reg_pending)
      begin
         if (reg_nv_write)
         begin
            arm <= reg_data[eeprom_pkg::ARM_BIT];
            block_protect <= reg_data[eeprom_pkg::BLOCK_HIGH_BIT:eeprom_pkg::BLOCK_LOW_BIT];
            reg_latch <= 1'b0;
         end
         else if (reg_data[eeprom_pkg::REG_LATCH_BIT] && reg_data[eeprom_pkg::SW_LATCH_BIT] && sw_latch)
            reg_latch <= 1'b1;
         else if (reg_data[7:2] == 6'h00)
         begin
            sw_latch <= reg_data[eeprom_pkg::SW_LATCH_BIT];
            if (!reg_data[eeprom_pkg::SW_LATCH_BIT])
               reg_latch <= 1'b0;
         end
      end
   end

   // Commit engine: drains the page into the array, then waits out programming
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cstate <= eeprom_pkg::cm_idle;
         cnt <= '0;
      end
      else
      begin
         unique case (cstate)
            eeprom_pkg::cm_idle:
            begin
               cnt <= '0;
               if (commit_go)
                  cstate <= eeprom_pkg::cm_drain;
            end
            eeprom_pkg::cm_drain:
            begin
               if (!fifo_rd_valid)
                  cstate <= eeprom_pkg::cm_hold;
            end
            eeprom_pkg::cm_hold:
            begin
               if (cnt == CNT_W'(WRITE_CYCLES - 1))
                  cstate <= eeprom_pkg::cm_idle;
               else
                  cnt <= cnt + CNT_W'(1);
            end
            default:
               cstate <= eeprom_pkg::cm_idle;
         endcase
      end
   end

   wire drain = cstate == eeprom_pkg::cm_drain;

   always_ff @(posedge i_clk)
   begin
      if (drain && fifo_rd_valid)
         mem[commit_addr] <= fifo_rd_data[eeprom_pkg::BYTE_BITS-1:0];
   end

   // Page staging; it empties only while programming or on a flush, so a full page refuses the next byte
   stream_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(PAGE_BYTES)
   ) u_page (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_flush(flush),
      .i_wr_valid(push_valid),
      .o_wr_ready(fifo_wr_ready),
      .i_wr_data(push_data),
      .o_rd_valid(fifo_rd_valid),
      .i_rd_ready(drain),
      .o_rd_data(fifo_rd_data)
   );
endmodule : two_wire_eeprom_slave_port

/* tb/two_wire_eeprom_slave_port_sva.sv */
`timescale 1ns/100ps
module two_wire_eeprom_slave_port_sva #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   input wire logic i_select_pin_one,
   input wire logic i_select_pin_two_inverted_n,
   input wire logic i_write_protect,
   input wire logic o_busy
);
   int unsigned busy_len;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   // Length of the current programming run
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || !o_busy)
         busy_len <= 0;
      else
         busy_len <= busy_len + 1;
   end
   AST_OPEN_DRAIN: assert property (o_sda == 1'b0)
      else $error("sda output value is not zero");
   AST_RESET_QUIET: assert property ($rose(i_resetn) |-> !o_sda_oe && !o_busy)
      else $error("outputs active right after reset");
   // Previous sample, since the enable lags the wire by three clock edges
   AST_OE_SCL_LOW: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
      else $error("sda enable changed while scl high");
   AST_BUSY_SILENT: assert property (o_busy |-> !o_sda_oe)
      else $error("sda driven while programming");
   AST_BUSY_AT_STOP: assert property ($rose(o_busy) |-> i_scl && i_sda)
      else $error("programming began outside a stop");
   AST_BUSY_MIN: assert property ($fell(o_busy) |-> busy_len >= WRITE_CYCLES)
      else $error("programming run too short");
   AST_BUSY_MAX: assert property (o_busy |-> busy_len < WRITE_CYCLES + 400)
      else $error("programming run too long");
   AST_IDLE_RELEASED: assert property (i_scl [*8] |-> !o_sda_oe)
      else $error("sda held while bus idle");
   AST_START_RELEASED: assert property (i_scl && $past(i_scl) && $fell(i_sda) |-> ##1 !o_sda_oe [*4])
      else $error("sda driven after a start");
   COV_PROG: cover property ($rose(o_busy));
   COV_PROG_DONE: cover property ($fell(o_busy));
   COV_ACK: cover property ($rose(o_sda_oe));
endmodule : two_wire_eeprom_slave_port_sva
bind two_wire_eeprom_slave_port two_wire_eeprom_slave_port_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_select_pin_one(i_select_pin_one), .i_select_pin_two_inverted_n(i_select_pin_two_inverted_n),
   .i_write_protect(i_write_protect), .o_busy(o_busy));

/* tb/two_wire_master_model.sv */
`timescale 1ns/100ps
module two_wire_master_model (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // SCL stands high and SDA is released between frames
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Data moves only with SCL low; sampled late in the high phase
   task automatic clk_bit(input logic b, output logic g);
   begin
      #8 o_sda_low = ~b;
      #24 o_scl = 1'b1;
      #32 g = i_sda;
      o_scl = 1'b0;
   end
   endtask : clk_bit
   task automatic start_cond;
   begin
      #8 o_sda_low = 1'b0;
      #24 o_scl = 1'b1;
      #32 o_sda_low = 1'b1;
      #32 o_scl = 1'b0;
   end
   endtask : start_cond
   // Caller stops only after the transmitter has let go
   task automatic stop_cond;
   begin
      #8 o_sda_low = 1'b1;
      #24 o_scl = 1'b1;
      #32 o_sda_low = 1'b0;
      #32;
   end
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic g;
   begin
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], g);
      clk_bit(1'b1, g);
      ack = ~g;
   end
   endtask : send_byte
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic g;
   begin
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, d[i]);
      clk_bit(~ack, g);
   end
   endtask : recv_byte
endmodule : two_wire_master_model

/* tb/two_wire_eeprom_slave_port_tb.sv */
`timescale 1ns/100ps
module two_wire_eeprom_slave_port_tb;
   localparam int unsigned PROG_CLKS = 400;
   logic i_clk;
   logic i_resetn;
   logic sel_one;
   logic sel_two_n;
   logic wp;
   logic scl;
   logic master_low;
   logic sda_oe;
   logic busy;
   logic ack;
   logic [7:0] rdat;
   wire sda_line;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   // Pulled-up shared wire
   assign sda_line = !(master_low || sda_oe);
   two_wire_eeprom_slave_port #(.WRITE_CYCLES(PROG_CLKS)) uut (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_scl(scl), .i_sda(sda_line), .o_sda(), .o_sda_oe(sda_oe), .i_select_pin_one(sel_one),
      .i_select_pin_two_inverted_n(sel_two_n), .i_write_protect(wp), .o_busy(busy));
   two_wire_master_model m (.i_sda(sda_line), .o_scl(scl), .o_sda_low(master_low));
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic stop_test;
   begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask : stop_test
   task automatic chk_bit(input logic g, input logic e);
   begin
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   end
   endtask : chk_bit
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
   begin
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   end
   endtask : chk_byte
   task automatic wait_busy(input logic lvl);
      int n;
   begin
      n = 0;
      while (busy !== lvl && n < 3000)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk_bit(busy, lvl);
   end
   endtask : wait_busy
   function automatic logic [7:0] sbyte(input logic [12:0] a, input logic r);
      return {sel_one, ~sel_two_n, a[12:8], r};
   endfunction : sbyte
   // Programming expected when prog is 1, forbidden when 0, unknown when x
   task automatic wr(input logic [12:0] a, input logic [7:0] d, input int n, input logic dack, input logic prog);
   begin
      m.start_cond();
      m.send_byte(sbyte(a, 1'b0), ack);
      chk_bit(ack, 1'b1);
      m.send_byte(a[7:0], ack);
      chk_bit(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         m.send_byte(d + 8'(i), ack);
         chk_bit(ack, dack);
      end
      m.stop_cond();
      repeat (10) @(posedge i_clk);
      #1;
      if (prog === 1'b0)
         chk_bit(busy, 1'b0);
      if (prog === 1'b1)
      begin
         chk_bit(busy, 1'b1);
         m.start_cond();
         m.send_byte(sbyte(a, 1'b0), ack);
         chk_bit(ack, 1'b0);
         m.stop_cond();
         wait_busy(1'b0);
         m.start_cond();
         m.send_byte(sbyte(a, 1'b0), ack);
         chk_bit(ack, 1'b1);
         m.stop_cond();
      end
      wait_busy(1'b0);
   end
   endtask : wr
   task automatic rd(input logic [12:0] a, input logic [7:0] e, input int n);
   begin
      m.start_cond();
      m.send_byte(sbyte(a, 1'b0), ack);
      m.send_byte(a[7:0], ack);
      chk_bit(ack, 1'b1);
      m.start_cond();
      m.send_byte(sbyte(a, 1'b1), ack);
      chk_bit(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         m.recv_byte(i < n - 1, rdat);
         chk_byte(rdat, e + 8'(i));
      end
      m.stop_cond();
      repeat (10) @(posedge i_clk);
      #1;
   end
   endtask : rd
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         stop_test();
      end
   end
   initial
   begin
      i_resetn = 1'b0;
      sel_one = 1'b1;
      sel_two_n = 1'b0;
      wp = 1'b0;
      repeat (12) @(posedge i_clk);
      #1 i_resetn = 1'b1;
      chk_bit(busy, 1'b0);
      chk_bit(sda_oe, 1'b0);
      repeat (4) @(posedge i_clk);
      // Every pin setting against every select code; ends with pins 1 and 0
      for (int p = 0; p < 4; p++)
      begin
         #1 {sel_one, sel_two_n} = 2'(p) ^ 2'h1;
         for (int c = 0; c < 4; c++)
         begin
            m.start_cond();
            m.send_byte({2'(c), 6'h00}, ack);
            chk_bit(ack, {sel_one, ~sel_two_n} == 2'(c));
            m.stop_cond();
         end
         @(posedge i_clk);
      end
      #1;
      wr(13'h0040, 8'h11, 1, 1'b0, 1'b0);
      wr(13'h1fff, 8'h02, 1, 1'b1, 1'b0);
      rd(13'h1fff, 8'h02, 1);
      wr(13'h011e, 8'ha0, 4, 1'b1, 1'b1);
      rd(13'h0100, 8'ha2, 2);
      rd(13'h011e, 8'ha0, 2);
      wr(13'h1800, 8'h55, 1, 1'b1, 1'b1);
      wr(13'h1fff, 8'h06, 1, 1'b1, 1'b0);
      wr(13'h1fff, 8'h0a, 1, 1'b1, 1'b1);
      rd(13'h1fff, 8'h0a, 1);
      wr(13'h1800, 8'haa, 1, 1'b1, 1'b0);
      rd(13'h1800, 8'h55, 1);
      wr(13'h17ff, 8'h66, 1, 1'b1, 1'b1);
      rd(13'h17ff, 8'h66, 1);
      // Arm the hardware lock, then the pin decides whether the register may change
      wr(13'h1fff, 8'h06, 1, 1'b1, 1'b0);
      wr(13'h1fff, 8'h8a, 1, 1'b1, 1'b1);
      wp = 1'b1;
      wr(13'h1fff, 8'h06, 1, 1'b1, 1'b0);
      wr(13'h1fff, 8'h82, 1, 1'b1, 1'b0);
      rd(13'h1fff, 8'h8e, 1);
      wp = 1'b0;
      wr(13'h1fff, 8'h82, 1, 1'b1, 1'b1);
      rd(13'h1fff, 8'h82, 1);
      // Stop in the middle of a data byte
      m.start_cond();
      m.send_byte(sbyte(13'h0200, 1'b0), ack);
      m.send_byte(8'h00, ack);
      m.send_byte(8'h5a, ack);
      chk_bit(ack, 1'b1);
      repeat (4) m.clk_bit(1'b1, rdat[0]);
      m.stop_cond();
      repeat (10) @(posedge i_clk);
      chk_bit(busy, 1'b0);
      stop_test();
   end
endmodule : two_wire_eeprom_slave_port_tb
